// >>> design/ccmp_regs.vh
`ifndef CCMP_REGS_VH
`define CCMP_REGS_VH
`define CCMP_ADDR_CTRL 4'h0
`define CCMP_ADDR_STAT 4'h1
`define CCMP_ADDR_ADDR 4'h2
`define CCMP_ADDR_TAG 4'h3
`define CCMP_ADDR_WDATA 4'h4
`define CCMP_ADDR_RDATA 4'h5
`define CCMP_ADDR_CMD 4'h6
`define CCMP_ADDR_MODE 4'h7
`define CCMP_CTRL_RESET 32'h00000000
`define CCMP_CTRL_PAR_EN 0
`define CCMP_CTRL_OE_POL 1
`define CCMP_CTRL_WE_POL 2
`define CCMP_CMD_GO 0
`define CCMP_CMD_WRITE 1
`define CCMP_CMD_ASYNC 2
`define CCMP_CMD_DCACHE 3
`define CCMP_CMD_VALID 4
`define CCMP_CMD_TYPE 7:5
`define CCMP_STAT_PARITY_FAULT_N 0
`define CCMP_STAT_BERR 1
`define CCMP_STAT_MISS 2
`define CCMP_STAT_BUSY 3
`define CCMP_STAT_VALID 4
`define CCMP_ASYNC_SETTLE 3'h4
`endif

// >>> design/ccmp_top.v
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ccmp_regs.vh"
module ccmp_top (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Shared buses
  input wire [31:0] data_in,
  output reg [31:0] data_out,
  output reg data_oe_n,
  input wire [3:0] data_parity_bus_in,
  output reg [3:0] data_parity_bus_out,
  output reg data_parity_bus_oe_n,
  input wire [18:0] tag_in,
  output reg [18:0] tag_out,
  output reg tag_oe_n,
  input wire valid_in,
  output reg valid_out,
  output reg valid_oe_n,
  output reg [23:0] low_byte_address_bus,
  output reg sync_oe_n,
  // Cache control
  output reg icache_output_enable,
  output reg icache_write_enable,
  output reg icache_latch_clock,
  output reg dcache_output_enable,
  output reg dcache_write_enable,
  output reg dcache_latch_clock,
  // Asynchronous memory
  output reg read_buffer_transceiver_enable,
  output reg [1:0] access_type_code,
  output reg access_type_hi_or_parity_fault_n,
  output reg async_write_strobe,
  output reg async_read_strobe,
  input wire transfer_fault_in,
  input wire read_stall_hold,
  input wire write_stall_hold,
  // Processor control
  output reg run,
  output reg exception,
  output reg system_clock_out,
  output reg coprocessor_sync_clock,
  input wire coprocessor_stall_request,
  input wire [3:0] coprocessor_condition_in,
  input wire dma_hold_request,
  input wire [5:0] int_in,
  input wire double_rate_system_clock
);
  localparam ST_IDLE = 3'd0;
  localparam ST_SYNC = 3'd1;
  localparam ST_ARD = 3'd2;
  localparam ST_AWR = 3'd3;
  localparam ST_DONE = 3'd4;

  // Two-stage synchronisers for every outside input except the register port and reset.
  reg [31:0] data_s1, data_s2;
  reg [3:0] par_s1, par_s2;
  reg [18:0] tag_s1, tag_s2;
  reg val_s1, val_s2;
  reg [5:0] misc_s1, misc_s2;
  reg [3:0] cond_s1, cond_s2;
  reg [5:0] int_s1, int_s2;
  always @(posedge clk_sys) begin
    data_s1 <= data_in;
    data_s2 <= data_s1;
    par_s1 <= data_parity_bus_in;
    par_s2 <= par_s1;
    tag_s1 <= tag_in;
    tag_s2 <= tag_s1;
    val_s1 <= valid_in;
    val_s2 <= val_s1;
    misc_s1 <= {double_rate_system_clock, transfer_fault_in, read_stall_hold,
      write_stall_hold, coprocessor_stall_request, dma_hold_request};
    misc_s2 <= misc_s1;
    cond_s1 <= coprocessor_condition_in;
    cond_s2 <= cond_s1;
    int_s1 <= int_in;
    int_s2 <= int_s1;
  end
  wire clk2x = misc_s2[5];
  wire bus_fault = misc_s2[4];
  wire rd_hold = misc_s2[3];
  wire wr_hold = misc_s2[2];
  wire cp_busy = misc_s2[1];
  wire dma_hold = misc_s2[0];

  reg clk2x_d;
  reg sys_div;
  reg [31:0] ctrl;
  reg [5:0] mode;
  reg mode_taken;
  reg parity_fault_n_flag, berr_flag, miss_flag, valid_flag;
  reg [23:0] addr_r;
  reg [18:0] tag_r;
  reg [31:0] wdata_r, rdata_r;
  reg [7:0] cmd_r;
  reg [2:0] state;
  reg [31:0] next_rdata;
  reg [2:0] async_age;
  // The stall inputs reach the sequencer several cycles after the strobe leaves the pin,
  // so they are ignored until a reply to this transfer's strobe can have arrived.
  wire async_ready = (async_age == `CCMP_ASYNC_SETTLE);
  wire clk2x_rise = clk2x & ~clk2x_d;
  wire sys_edge = clk2x_rise & ~sys_div;
  wire stall = cp_busy | (dma_hold & (state == ST_SYNC));
  wire par_en = ctrl[`CCMP_CTRL_PAR_EN];
  wire oe_pol = ctrl[`CCMP_CTRL_OE_POL];
  wire we_pol = ctrl[`CCMP_CTRL_WE_POL];
  wire [3:0] gen_par = {^wdata_r[31:24], ^wdata_r[23:16],
    ^wdata_r[15:8], ^wdata_r[7:0]};
  wire [3:0] chk_par = {^data_s2[31:24], ^data_s2[23:16],
    ^data_s2[15:8], ^data_s2[7:0]} ^ par_s2;
  wire par_bad = par_en & (|chk_par);
  wire sw_clr_parity_fault_n = reg_wr & (reg_addr == `CCMP_ADDR_STAT) & reg_wdata[`CCMP_STAT_PARITY_FAULT_N];
  wire sw_clr_berr = reg_wr & (reg_addr == `CCMP_ADDR_STAT) & reg_wdata[`CCMP_STAT_BERR];
  wire go = reg_wr & (reg_addr == `CCMP_ADDR_CMD) & reg_wdata[`CCMP_CMD_GO];
  wire chk_point = (state == ST_SYNC) & ~stall & ~cmd_r[`CCMP_CMD_WRITE];
  wire parity_fault_n_set = chk_point & par_bad;
  wire berr_set = ((state == ST_ARD) | (state == ST_AWR)) & bus_fault;

  // Latch clocks and system clock derive from the double-rate input.
  always @(posedge clk_sys) begin
    clk2x_d <= clk2x;
    if (srst) begin
      sys_div <= 1'b0;
      system_clock_out <= 1'b0;
      coprocessor_sync_clock <= 1'b0;
      icache_latch_clock <= 1'b0;
      dcache_latch_clock <= 1'b0;
    end else if (clk2x_rise) begin
      sys_div <= ~sys_div;
      system_clock_out <= ~sys_div;
      coprocessor_sync_clock <= ~sys_div;
      icache_latch_clock <= ~sys_div;
      dcache_latch_clock <= ~sys_div;
    end
  end

  // Mode is captured once at the first system clock edge after reset.
  always @(posedge clk_sys) begin
    if (srst) begin
      mode_taken <= 1'b0;
      mode <= 6'h00;
    end else if (!mode_taken && sys_edge) begin
      mode_taken <= 1'b1;
      mode <= int_s2;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= `CCMP_CTRL_RESET;
      addr_r <= 24'h000000;
      tag_r <= 19'h00000;
      wdata_r <= 32'h00000000;
      cmd_r <= 8'h00;
      parity_fault_n_flag <= 1'b0;
      berr_flag <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `CCMP_ADDR_CTRL) ctrl <= reg_wdata;
      if (reg_wr && reg_addr == `CCMP_ADDR_ADDR) addr_r <= reg_wdata[23:0];
      if (reg_wr && reg_addr == `CCMP_ADDR_TAG) tag_r <= reg_wdata[18:0];
      if (reg_wr && reg_addr == `CCMP_ADDR_WDATA) wdata_r <= reg_wdata;
      if (go && state == ST_IDLE) cmd_r <= reg_wdata[7:0];
      if (parity_fault_n_set) parity_fault_n_flag <= 1'b1;
      else if (sw_clr_parity_fault_n) parity_fault_n_flag <= 1'b0;
      if (berr_set) berr_flag <= 1'b1;
      else if (sw_clr_berr) berr_flag <= 1'b0;
    end
  end

  // Transfer sequencer.
  always @(posedge clk_sys) begin
    if (srst || !mode_taken) begin
      state <= ST_IDLE;
      rdata_r <= 32'h00000000;
      miss_flag <= 1'b0;
      valid_flag <= 1'b0;
      exception <= 1'b0;
      async_age <= 3'h0;
    end else begin
      exception <= 1'b0;
      case (state)
        ST_IDLE: begin
          async_age <= 3'h0;
          if (go) begin
            state <= reg_wdata[`CCMP_CMD_ASYNC] ? (reg_wdata[`CCMP_CMD_WRITE] ?
              ST_AWR : ST_ARD) : ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (!stall) begin
            rdata_r <= data_s2;
            valid_flag <= val_s2;
            miss_flag <= ~cmd_r[`CCMP_CMD_WRITE] & (par_bad | ~val_s2);
            state <= ST_DONE;
          end
        end
        ST_ARD: begin
          if (!async_ready) async_age <= async_age + 3'h1;
          if (bus_fault) begin
            exception <= 1'b1;
            state <= ST_DONE;
          end else if (async_ready && !rd_hold && !cp_busy) begin
            rdata_r <= data_s2;
            miss_flag <= 1'b0;
            state <= ST_DONE;
          end
        end
        ST_AWR: begin
          if (!async_ready) async_age <= async_age + 3'h1;
          if (bus_fault) begin
            exception <= 1'b1;
            state <= ST_DONE;
          end else if (async_ready && !wr_hold && !cp_busy) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pin drive.
  always @(posedge clk_sys) begin
    if (srst) begin
      data_out <= 32'h00000000;
      data_oe_n <= 1'b1;
      data_parity_bus_out <= 4'h0;
      data_parity_bus_oe_n <= 1'b1;
      tag_out <= 19'h00000;
      tag_oe_n <= 1'b1;
      valid_out <= 1'b0;
      valid_oe_n <= 1'b1;
      low_byte_address_bus <= 24'h000000;
      sync_oe_n <= 1'b1;
      icache_output_enable <= 1'b0;
      icache_write_enable <= 1'b0;
      dcache_output_enable <= 1'b0;
      dcache_write_enable <= 1'b0;
      read_buffer_transceiver_enable <= 1'b1;
      access_type_code <= 2'b00;
      access_type_hi_or_parity_fault_n <= 1'b1;
      async_write_strobe <= 1'b0;
      async_read_strobe <= 1'b0;
      run <= 1'b0;
    end else begin : drive
      reg wr_cyc, sync_cyc, async_cyc, dc;
      wr_cyc = cmd_r[`CCMP_CMD_WRITE];
      sync_cyc = (state == ST_SYNC) & ~stall;
      async_cyc = (state == ST_ARD) | (state == ST_AWR);
      dc = cmd_r[`CCMP_CMD_DCACHE];
      data_out <= wdata_r;
      data_oe_n <= ~(wr_cyc & (sync_cyc | async_cyc));
      data_parity_bus_out <= gen_par;
      data_parity_bus_oe_n <= ~(wr_cyc & (sync_cyc | async_cyc));
      tag_out <= tag_r;
      tag_oe_n <= ~((wr_cyc & sync_cyc) | async_cyc);
      valid_out <= cmd_r[`CCMP_CMD_VALID];
      valid_oe_n <= ~(wr_cyc & sync_cyc);
      low_byte_address_bus <= addr_r;
      sync_oe_n <= dma_hold;
      icache_output_enable <= oe_pol ^ ~(sync_cyc & ~wr_cyc & ~dc);
      icache_write_enable <= we_pol ^ ~(sync_cyc & wr_cyc & ~dc);
      dcache_output_enable <= oe_pol ^ ~(sync_cyc & ~wr_cyc & dc);
      dcache_write_enable <= we_pol ^ ~(sync_cyc & wr_cyc & dc);
      read_buffer_transceiver_enable <= ~(state == ST_ARD);
      access_type_code <= cmd_r[6:5];
      if (mode[0]) access_type_hi_or_parity_fault_n <= ~parity_fault_n_flag;
      else access_type_hi_or_parity_fault_n <= cmd_r[7];
      async_read_strobe <= (state == ST_ARD);
      async_write_strobe <= (state == ST_AWR);
      run <= ~(stall | async_cyc) & mode_taken;
    end
  end

  // Register reads; the refill gate exposes condition bit zero.
  always @* begin
    case (reg_addr)
      `CCMP_ADDR_CTRL: next_rdata = ctrl;
      `CCMP_ADDR_STAT: next_rdata = {25'h0000000, cond_s2[0], cond_s2[3:1] != 3'b000,
        valid_flag, state != ST_IDLE, miss_flag, berr_flag, parity_fault_n_flag};
      `CCMP_ADDR_ADDR: next_rdata = {8'h00, addr_r};
      `CCMP_ADDR_TAG: next_rdata = {13'h0000, tag_s2};
      `CCMP_ADDR_WDATA: next_rdata = wdata_r;
      `CCMP_ADDR_RDATA: next_rdata = rdata_r;
      `CCMP_ADDR_CMD: next_rdata = {24'h000000, cmd_r};
      `CCMP_ADDR_MODE: next_rdata = {20'h00000, cond_s2, 2'b00, mode};
      default: next_rdata = 32'h00000000;
    endcase
  end
  always @(posedge clk_sys) begin
    if (srst) reg_rdata <= 32'h00000000;
    else if (reg_rd) reg_rdata <= next_rdata;
    else reg_rdata <= 32'h00000000;
  end
endmodule
`default_nettype wire

// >>> bench/ccmp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ccmp_properties (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Watched pins
  input wire [31:0] data_out,
  input wire data_oe_n,
  input wire [3:0] data_parity_bus_out,
  input wire data_parity_bus_oe_n,
  input wire sync_oe_n,
  input wire dma_hold_request,
  input wire icache_latch_clock,
  input wire dcache_latch_clock,
  input wire system_clock_out,
  input wire coprocessor_sync_clock,
  input wire read_buffer_transceiver_enable,
  input wire async_read_strobe,
  input wire async_write_strobe,
  input wire read_stall_hold,
  input wire write_stall_hold,
  input wire transfer_fault_in,
  input wire exception,
  input wire run
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sync_copy_a: assert property (coprocessor_sync_clock == system_clock_out)
    else $error("sync clock differs");
  latch_clock_a: assert property (icache_latch_clock == system_clock_out &&
    dcache_latch_clock == system_clock_out) else $error("latch clock differs");
  parity_gen_a: assert property (!data_oe_n && !data_parity_bus_oe_n |->
    data_parity_bus_out == {^data_out[31:24], ^data_out[23:16], ^data_out[15:8],
    ^data_out[7:0]}) else $error("bad parity out");
  read_xcvr_a: assert property (async_read_strobe |-> !read_buffer_transceiver_enable)
    else $error("transceiver off in read");
  dma_float_a: assert property (dma_hold_request [*5] |-> sync_oe_n)
    else $error("sync pins driven in dma hold");
  exc_pulse_a: assert property (exception |=> !exception)
    else $error("exception too long");
  reset_out_a: assert property ($fell(srst) |-> data_oe_n && !run &&
    !async_read_strobe && !async_write_strobe) else $error("bad reset outputs");
  write_hold_a: assert property ((async_write_strobe && write_stall_hold &&
    !transfer_fault_in) [*5] |=> async_write_strobe) else $error("write ended early");
  read_hold_a: assert property ((async_read_strobe && read_stall_hold &&
    !transfer_fault_in) [*5] |=> async_read_strobe) else $error("read ended early");
endmodule
bind ccmp_top ccmp_properties u_ccmp_properties (.*);
`default_nettype wire

// >>> bench/ccmp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccmp_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Device pins
  input wire logic async_read_strobe,
  input wire logic async_write_strobe,
  input wire logic data_oe_n,
  input wire logic [31:0] data_out,
  output logic [31:0] data_in,
  output logic [3:0] data_parity_bus_in,
  output logic [18:0] tag_in,
  output logic valid_in,
  output logic read_stall_hold,
  output logic write_stall_hold,
  output logic transfer_fault_in,
  // Scenario control
  input wire logic [31:0] word,
  input wire logic [3:0] wait_n,
  input wire logic bad_par,
  input wire logic fault
);
  logic [3:0] cnt;
  // The shared bus shows the device value while it drives.
  assign data_in = data_oe_n ? word : data_out;
  assign data_parity_bus_in = {^word[31:24], ^word[23:16], ^word[15:8],
    ^word[7:0] ^ bad_par};
  assign tag_in = word[18:0];
  assign valid_in = 1'b1;
  always @(posedge clk_sys) begin
    if (srst || !(async_read_strobe || async_write_strobe)) begin
      cnt <= 4'h0;
      read_stall_hold <= 1'b1;
      write_stall_hold <= 1'b0;
      transfer_fault_in <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      write_stall_hold <= cnt < wait_n || fault;
      if (cnt >= wait_n) begin
        read_stall_hold <= fault;
        transfer_fault_in <= fault;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/ccmp_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccmp_regs.vh"
module ccmp_top_test;
  logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, coprocessor_condition_in = 4'h5, wait_n = 4'h3;
  logic [31:0] reg_wdata = 32'h0, word = 32'hA5C30F96;
  logic dma_hold_request = 1'b0, coprocessor_stall_request = 1'b0;
  logic bad_par = 1'b0, fault = 1'b0, double_rate_system_clock = 1'b0;
  logic [5:0] int_in = 6'h21;
  wire [31:0] reg_rdata, data_in, data_out;
  wire [23:0] low_byte_address_bus;
  wire [18:0] tag_in;
  wire [3:0] data_parity_bus_in;
  wire [1:0] access_type_code;
  wire data_oe_n, valid_in, sync_oe_n, access_type_hi_or_parity_fault_n, run, exception;
  wire async_write_strobe, async_read_strobe, transfer_fault_in;
  wire read_stall_hold, write_stall_hold;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2 clk_sys = ~clk_sys;
  initial begin
    #7.3;
    forever #40 double_rate_system_clock = ~double_rate_system_clock;
  end
  ccmp_top u_ccmp_top (.*, .data_parity_bus_out(), .data_parity_bus_oe_n(), .tag_out(),
    .tag_oe_n(), .valid_out(), .valid_oe_n(), .icache_output_enable(),
    .icache_write_enable(), .icache_latch_clock(), .dcache_output_enable(),
    .dcache_write_enable(), .dcache_latch_clock(), .read_buffer_transceiver_enable(),
    .system_clock_out(), .coprocessor_sync_clock());
  ccmp_mem_model u_ccmp_mem_model (.*);
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic idle(output logic [31:0] s);
    for (int i = 0; i < 80; i++) begin
      rd(`CCMP_ADDR_STAT, s);
      if (s[`CCMP_STAT_BUSY] === 1'b0) return;
    end
    n_mismatch++;
    final_report();
  endtask
  task automatic t_mode;
    logic [31:0] q;
    rd(`CCMP_ADDR_CTRL, q);
    chk(q, `CCMP_CTRL_RESET);
    int_in <= 6'h0C;
    coprocessor_condition_in <= 4'hA;
    repeat (8) @(posedge clk_sys);
    rd(`CCMP_ADDR_MODE, q);
    chk({20'h0, q[11:8], 2'h0, q[5:0]}, 32'h00000A21);
  endtask
  task automatic t_aread;
    logic [31:0] q;
    wr(`CCMP_ADDR_ADDR, 32'h00ABCDEF);
    wr(`CCMP_ADDR_CMD, 32'h000000A5);
    for (int i = 0; i < 20 && async_read_strobe !== 1'b1; i++) @(posedge clk_sys);
    chk({8'h0, low_byte_address_bus}, 32'h00ABCDEF);
    chk({30'h0, access_type_code}, 32'h00000001);
    idle(q);
    rd(`CCMP_ADDR_RDATA, q);
    chk(q, word);
  endtask
  task automatic t_awrite;
    logic [31:0] q;
    wait_n <= 4'hC;
    wr(`CCMP_ADDR_WDATA, 32'h12345678);
    wr(`CCMP_ADDR_CMD, 32'h00000007);
    for (int i = 0; i < 20 && async_write_strobe !== 1'b1; i++) @(posedge clk_sys);
    chk({31'h0, data_oe_n}, 32'h0);
    chk(data_out, 32'h12345678);
    idle(q);
    chk({31'h0, q[`CCMP_STAT_BERR]}, 32'h0);
    wait_n <= 4'h3;
  endtask
  task automatic t_fault;
    logic [31:0] q;
    fault <= 1'b1;
    wr(`CCMP_ADDR_CMD, 32'h00000005);
    idle(q);
    chk({31'h0, q[`CCMP_STAT_BERR]}, 32'h1);
    fault <= 1'b0;
    wr(`CCMP_ADDR_STAT, 32'h00000002);
    rd(`CCMP_ADDR_STAT, q);
    chk({31'h0, q[`CCMP_STAT_BERR]}, 32'h0);
  endtask
  task automatic t_parity;
    logic [31:0] q;
    wr(`CCMP_ADDR_WDATA, 32'h80C1F00F);
    wr(`CCMP_ADDR_CMD, 32'h0000001B);
    idle(q);
    wr(`CCMP_ADDR_CTRL, 32'h00000001);
    bad_par <= 1'b1;
    wr(`CCMP_ADDR_CMD, 32'h00000001);
    idle(q);
    chk({30'h0, q[`CCMP_STAT_MISS], q[`CCMP_STAT_PARITY_FAULT_N]}, 32'h3);
    chk({31'h0, access_type_hi_or_parity_fault_n}, 32'h0);
    bad_par <= 1'b0;
    wr(`CCMP_ADDR_STAT, 32'h00000001);
    rd(`CCMP_ADDR_STAT, q);
    chk({31'h0, access_type_hi_or_parity_fault_n}, 32'h1);
    wr(`CCMP_ADDR_CTRL, 32'h00000000);
  endtask
  task automatic t_stall;
    logic [31:0] q;
    coprocessor_stall_request <= 1'b1;
    wr(`CCMP_ADDR_CMD, 32'h00000001);
    repeat (10) @(posedge clk_sys);
    rd(`CCMP_ADDR_STAT, q);
    chk({31'h0, q[`CCMP_STAT_BUSY]}, 32'h1);
    coprocessor_stall_request <= 1'b0;
    idle(q);
    dma_hold_request <= 1'b1;
    wr(`CCMP_ADDR_CMD, 32'h00000001);
    repeat (8) @(posedge clk_sys);
    chk({31'h0, sync_oe_n}, 32'h1);
    rd(`CCMP_ADDR_STAT, q);
    chk({31'h0, q[`CCMP_STAT_BUSY]}, 32'h1);
    dma_hold_request <= 1'b0;
    idle(q);
    chk({31'h0, sync_oe_n}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (120) @(posedge clk_sys);
    t_mode();
    t_aread();
    t_awrite();
    t_fault();
    t_parity();
    t_stall();
    final_report();
  end
endmodule
`default_nettype wire
